/* inc/otrb_consts.vh */
/*
  Constants of the oscillator trim register bank: register indices,
  field positions, write masks, reset values and loader states.
  Assumes inclusion by bare name from the design files under src/.

// Behaviour
// - Factory test register written only in special mode
// - Temperature trim loads from flash after reset
// - Bit 7 enables offset, else field ignored
// - Temperature trim field is binary weighted
// - Temperature trim register always readable and writable
// - Oscillator trim writes ignored while protected
// - Trim write with PLL selected clears status
// - Oscillator trim pair loads from flash after reset
// - Tempco field bits 15-11, two codes disable
// - Frequency field bits 9-0, coarse upper four
// - Lower six frequency bits give fine trim
*/
`ifndef OTRB_CONSTS_VH
`define OTRB_CONSTS_VH

// Bus widths
`define OTRB_ADDR_W 12
`define OTRB_DATA_W 32
`define OTRB_IDX_W 10

// Register indices, byte address is four times the index
`define OTRB_IDX_TEST 10'h2F6
`define OTRB_IDX_TEMP 10'h2F7
`define OTRB_IDX_OSCH 10'h2F8
`define OTRB_IDX_OSCL 10'h2F9

// Register select codes
`define OTRB_SEL_NONE 3'h0
`define OTRB_SEL_TEST 3'h1
`define OTRB_SEL_TEMP 3'h2
`define OTRB_SEL_OSCH 3'h3
`define OTRB_SEL_OSCL 3'h4

// Write masks of implemented bits
`define OTRB_MASK_TEMP 8'h8F
`define OTRB_MASK_OSCH 8'hFB
`define OTRB_MASK_OSCL 8'hFF

// Reset values, those of the temperature and oscillator trims valid until the flash load completes
`define OTRB_RST_TEST 8'h00
`define OTRB_RST_TEMP 8'h00
`define OTRB_RST_OSC 16'h0000

// Field positions
`define OTRB_TEMP_EN_BIT 7
`define OTRB_TEMP_FLD_HI 3
`define OTRB_TEMP_FLD_W 4
`define OTRB_TC_HI 15
`define OTRB_TC_LO 11
`define OTRB_TC_SIGN_BIT 4
`define OTRB_TC_MAG_HI 3
`define OTRB_COARSE_HI 9
`define OTRB_COARSE_LO 6
`define OTRB_FINE_HI 5
`define OTRB_FINE_LO 0

// Nominal step sizes in tenths of a percent
`define OTRB_COARSE_STEP_PERMIL 60
`define OTRB_FINE_STEP_PERMIL 3

// Flash loader states
`define OTRB_LD_REQ 2'h0
`define OTRB_LD_SETTLE 2'h1
`define OTRB_LD_DONE 2'h2

`endif

/* src/otrb_flash_loader.v */
/*
  Flash trim loader: after reset release asks the flash for the trim
  words once and signals when they may be captured.
  Assumes the flash answers flash_ack while flash_req is high, with
  the trim words valid in that same cycle.
*/
`timescale 1ns/1ps
`include "otrb_consts.vh"

module otrb_flash_loader (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Flash handshake
  input wire flash_ack,
  output wire flash_req,
  // Towards the register bank
  output wire load_strobe,
  output wire load_done
);

  reg [1:0] state_q;
  reg [1:0] state_d;

  // Request stands from reset release until the flash answers
  assign flash_req = (state_q == `OTRB_LD_REQ);
  assign load_strobe = flash_req & flash_ack;
  assign load_done = (state_q == `OTRB_LD_DONE);

  // Next state: one settle cycle lets loaded values reach read data
  always @* begin
    state_d = state_q;
    case (state_q)
      `OTRB_LD_REQ: begin
        if (flash_ack) begin
          state_d = `OTRB_LD_SETTLE;
        end
      end
      `OTRB_LD_SETTLE: begin
        state_d = `OTRB_LD_DONE;
      end
      default: begin
        state_d = `OTRB_LD_DONE;
      end
    endcase
  end

  // State register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= `OTRB_LD_REQ;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

/* src/otrb_trim_bank.v */
/*
  Oscillator trim register bank: factory test register, temperature
  sense trim and the 16-bit reference oscillator trim pair, reached
  over APB, the two trims loaded from flash after reset release.
  Assumes an APB master on pclk, chip mode, protection and PLL select
  levels from the rest of the clock unit, and a flash that answers
  the loader request once after reset.
*/
`timescale 1ns/1ps
`include "otrb_consts.vh"

module otrb_trim_bank (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`OTRB_ADDR_W-1:0] paddr,
  input wire [`OTRB_DATA_W-1:0] pwdata,
  output wire pready,
  output reg [`OTRB_DATA_W-1:0] prdata,
  output reg pslverr,
  // Chip state
  input wire special_mode,
  input wire register_protect,
  input wire pll_select,
  // Flash trim fetch
  input wire flash_ack,
  input wire [7:0] flash_temp_trim,
  input wire [15:0] flash_osc_trim,
  output wire flash_req,
  // Status clears towards the clock unit
  output reg pll_lock_clear,
  output reg osc_up_flag_clear,
  // Factory test control
  output reg [7:0] factory_test_out,
  // Temperature sense trim
  output reg temp_offset_enable,
  output reg [3:0] temp_trim_field,
  output reg [4:0] temp_threshold_voltage,
  // Reference oscillator trim
  output reg [4:0] tempco_trim_field,
  output reg tempco_comp_on,
  output reg [9:0] freq_trim_field,
  output reg [3:0] freq_coarse_trim,
  output reg [5:0] freq_fine_trim
);

  // Register storage
  reg [7:0] test_q;
  reg [7:0] temp_q;
  reg [15:0] osc_q;

  // Next values
  reg [7:0] test_d;
  reg [7:0] temp_d;
  reg [15:0] osc_d;

  // Bus side state
  wire load_strobe;
  wire load_done;
  wire [2:0] setup_sel;
  wire [2:0] acc_sel;
  wire setup_phase;
  wire wr_fire;
  wire wr_test;
  wire wr_temp;
  wire wr_osch;
  wire wr_oscl;
  wire osc_wr_ok;
  wire status_clr;
  reg [7:0] rd_byte;

  // Temperature threshold build-up
  wire [`OTRB_TEMP_FLD_W-1:0] temp_eff;
  wire [4:0] weight_sum [0:`OTRB_TEMP_FLD_W];

  // Maps a byte address onto a register select code
  function [2:0] reg_sel;
    input [`OTRB_ADDR_W-1:0] addr;
    reg [`OTRB_IDX_W-1:0] idx;
    begin
      idx = addr[`OTRB_ADDR_W-1:2];
      if (addr[1:0] != 2'h0) begin
        reg_sel = `OTRB_SEL_NONE;
      end else if (idx == `OTRB_IDX_TEST) begin
        reg_sel = `OTRB_SEL_TEST;
      end else if (idx == `OTRB_IDX_TEMP) begin
        reg_sel = `OTRB_SEL_TEMP;
      end else if (idx == `OTRB_IDX_OSCH) begin
        reg_sel = `OTRB_SEL_OSCH;
      end else if (idx == `OTRB_IDX_OSCL) begin
        reg_sel = `OTRB_SEL_OSCL;
      end else begin
        reg_sel = `OTRB_SEL_NONE;
      end
    end
  endfunction

  // Trim fetch after reset release
  otrb_flash_loader u_loader (
    .pclk(pclk),
    .presetn(presetn),
    .flash_ack(flash_ack),
    .flash_req(flash_req),
    .load_strobe(load_strobe),
    .load_done(load_done)
  );

  // Bus is stalled until the trim words are in place
  assign pready = load_done;

  // Decode in setup for read data, in access for writes
  assign setup_phase = psel & ~penable;
  assign setup_sel = reg_sel(paddr);
  assign acc_sel = reg_sel(paddr);
  assign wr_fire = psel & penable & pwrite & pready;

  // Per register write strobes
  assign wr_test = wr_fire & (acc_sel == `OTRB_SEL_TEST) & special_mode;
  assign wr_temp = wr_fire & (acc_sel == `OTRB_SEL_TEMP);
  assign osc_wr_ok = wr_fire & ~register_protect;
  assign wr_osch = osc_wr_ok & (acc_sel == `OTRB_SEL_OSCH);
  assign wr_oscl = osc_wr_ok & (acc_sel == `OTRB_SEL_OSCL);

  // Effective trim write with PLL selected clears lock and up flags
  assign status_clr = (wr_osch | wr_oscl) & pll_select;

  // Factory test register next value
  always @* begin
    test_d = test_q;
    if (wr_test) begin
      test_d = pwdata[7:0];
    end
  end

  // Temperature trim next value, flash load ahead of any write
  always @* begin
    temp_d = temp_q;
    if (load_strobe) begin
      temp_d = flash_temp_trim & `OTRB_MASK_TEMP;
    end else if (wr_temp) begin
      temp_d = pwdata[7:0] & `OTRB_MASK_TEMP;
    end
  end

  // Oscillator trim pair next value
  always @* begin
    osc_d = osc_q;
    if (load_strobe) begin
      osc_d = flash_osc_trim & {`OTRB_MASK_OSCH, `OTRB_MASK_OSCL};
    end else begin
      if (wr_osch) begin
        osc_d[15:8] = pwdata[7:0] & `OTRB_MASK_OSCH;
      end
      if (wr_oscl) begin
        osc_d[7:0] = pwdata[7:0] & `OTRB_MASK_OSCL;
      end
    end
  end

  // Register storage update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_q <= `OTRB_RST_TEST;
      temp_q <= `OTRB_RST_TEMP;
      osc_q <= `OTRB_RST_OSC;
    end else begin
      test_q <= test_d;
      temp_q <= temp_d;
      osc_q <= osc_d;
    end
  end

  // Read multiplexer, reserved bits already held at zero
  always @* begin
    rd_byte = 8'h00;
    if (setup_sel == `OTRB_SEL_TEST) begin
      rd_byte = test_q;
    end else if (setup_sel == `OTRB_SEL_TEMP) begin
      rd_byte = temp_q;
    end else if (setup_sel == `OTRB_SEL_OSCH) begin
      rd_byte = osc_q[15:8];
    end else if (setup_sel == `OTRB_SEL_OSCL) begin
      rd_byte = osc_q[7:0];
    end
  end

  // Read data and error flag captured in every setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= {`OTRB_DATA_W{1'b0}};
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= {{(`OTRB_DATA_W-8){1'b0}}, rd_byte};
      pslverr <= (setup_sel == `OTRB_SEL_NONE);
    end
  end

  // Status clear pulses, one cycle long, set at the write edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_lock_clear <= 1'b0;
      osc_up_flag_clear <= 1'b0;
    end else begin
      pll_lock_clear <= status_clr;
      osc_up_flag_clear <= status_clr;
    end
  end

  // Offset field only counts while the offset is enabled
  assign temp_eff = temp_q[`OTRB_TEMP_EN_BIT] ?
    temp_q[`OTRB_TEMP_FLD_HI:0] : {`OTRB_TEMP_FLD_W{1'b0}};

  // Each trim bit adds twice the step of the bit below it
  assign weight_sum[0] = 5'h00;
  genvar gi;
  generate
    for (gi = 0; gi < `OTRB_TEMP_FLD_W; gi = gi + 1) begin : g_weight
      assign weight_sum[gi+1] = weight_sum[gi] +
        (temp_eff[gi] ? (5'h01 << gi) : 5'h00);
    end
  endgenerate

  // Temperature sense controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_offset_enable <= 1'b0;
      temp_trim_field <= 4'h0;
      temp_threshold_voltage <= 5'h00;
    end else begin
      temp_offset_enable <= temp_q[`OTRB_TEMP_EN_BIT];
      temp_trim_field <= temp_q[`OTRB_TEMP_FLD_HI:0];
      temp_threshold_voltage <= weight_sum[`OTRB_TEMP_FLD_W];
    end
  end

  // Reference oscillator controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tempco_trim_field <= 5'h00;
      tempco_comp_on <= 1'b0;
      freq_trim_field <= 10'h000;
      freq_coarse_trim <= 4'h0;
      freq_fine_trim <= 6'h00;
    end else begin
      tempco_trim_field <= osc_q[`OTRB_TC_HI:`OTRB_TC_LO];
      // Magnitude zero means nominal coefficient, compensation off
      tempco_comp_on <= |osc_q[`OTRB_TC_LO+`OTRB_TC_MAG_HI:`OTRB_TC_LO];
      freq_trim_field <= osc_q[`OTRB_COARSE_HI:0];
      freq_coarse_trim <= osc_q[`OTRB_COARSE_HI:`OTRB_COARSE_LO];
      freq_fine_trim <= osc_q[`OTRB_FINE_HI:`OTRB_FINE_LO];
    end
  end

  // Factory test control output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factory_test_out <= `OTRB_RST_TEST;
    end else begin
      factory_test_out <= test_q;
    end
  end

endmodule

/* verification/otrb_trim_bank_properties.sv */
/*
  Port checker of the trim bank.
  Assumes binding to otrb_trim_bank; addresses are the byte addresses.
*/
`timescale 1ns/1ps
module otrb_trim_bank_properties (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Chip state and flash
  input wire special_mode,
  input wire register_protect,
  input wire pll_select,
  input wire flash_ack,
  input wire flash_req,
  // Watched outputs
  input wire pll_lock_clear,
  input wire osc_up_flag_clear,
  input wire [7:0] factory_test_out,
  input wire temp_offset_enable,
  input wire [3:0] temp_trim_field,
  input wire [4:0] temp_threshold_voltage,
  input wire [4:0] tempco_trim_field,
  input wire tempco_comp_on,
  input wire [9:0] freq_trim_field,
  input wire [3:0] freq_coarse_trim,
  input wire [5:0] freq_fine_trim
);
  // Completed accesses by target
  wire acc = psel && penable && pready;
  wire wr_test = acc && pwrite && paddr == 12'hBD8;
  wire wr_temp = acc && pwrite && paddr == 12'hBDC;
  wire wr_osc = acc && pwrite && (paddr == 12'hBE0 || paddr == 12'hBE4);
  wire rd_temp = acc && !pwrite && paddr == 12'hBDC;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Effective trim write with the PLL selected, then a one-cycle pulse
  sequence s_osc_go;
    wr_osc && !register_protect && pll_select;
  endsequence
  sequence s_pulse;
    pll_lock_clear && osc_up_flag_clear ##1 !pll_lock_clear;
  endsequence
  load_wait_a: assert property (flash_req && !flash_ack |=> flash_req)
    else $error("flash request dropped early");
  load_ready_a: assert property (flash_req && flash_ack |-> !pready ##2 pready)
    else $error("bus not ready two cycles after load");
  test_lock_a: assert property (wr_test && !special_mode |=> ##1 $stable(factory_test_out))
    else $error("test register written outside special mode");
  test_write_a: assert property (wr_test && special_mode |=> ##1
    factory_test_out == $past(pwdata[7:0], 2))
    else $error("test register write lost");
  temp_write_a: assert property (wr_temp |=> ##1 temp_trim_field == $past(pwdata[3:0], 2))
    else $error("temperature trim write lost");
  offset_gate_a: assert property (temp_threshold_voltage ==
    (temp_offset_enable ? {1'b0, temp_trim_field} : 5'h00))
    else $error("threshold not gated by offset enable");
  osc_protect_a: assert property (wr_osc && register_protect |=> ##1 $stable(freq_trim_field))
    else $error("protected trim write took effect");
  status_clear_a: assert property (s_osc_go |=> s_pulse)
    else $error("status clear pulse missing");
  tempco_off_a: assert property (tempco_comp_on == |tempco_trim_field[3:0])
    else $error("compensation enable wrong");
  coarse_split_a: assert property (freq_coarse_trim == freq_trim_field[9:6])
    else $error("coarse trim wrong");
  fine_split_a: assert property (freq_fine_trim == freq_trim_field[5:0])
    else $error("fine trim wrong");
  reserved_zero_a: assert property (rd_temp |-> prdata[6:4] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule
bind otrb_trim_bank otrb_trim_bank_properties u_props (.*);

/* verification/otrb_trim_bank_tb.sv */
/*
  Directed testbench of the trim bank over APB.
  Assumes the design and its constants header on the include path.
*/
`timescale 1ns/1ps
module otrb_trim_bank_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flash_ack = 0;
  logic special_mode = 0, register_protect = 0, pll_select = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] flash_temp_trim = 8'h85, factory_test_out;
  logic [15:0] flash_osc_trim = 16'hA5C3;
  logic pready, pslverr, flash_req, pll_lock_clear, osc_up_flag_clear;
  logic temp_offset_enable, tempco_comp_on;
  logic [3:0] temp_trim_field, freq_coarse_trim;
  logic [4:0] temp_threshold_voltage, tempco_trim_field;
  logic [9:0] freq_trim_field;
  logic [5:0] freq_fine_trim;
  int n_errors = 0, n_tests = 0, n_clr = 0;
  otrb_trim_bank dut (.*);
  // Clock of 8 ns
  always #4 pclk = ~pclk;
  // Count status clear pulses
  always @(posedge pclk) if (pll_lock_clear === 1'b1 && osc_up_flag_clear === 1'b1) n_clr++;
  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waits on pready
  task xfer(input [11:0] a, input w, input [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [11:0] a, input [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input [11:0] a, input [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(r, {24'h0, e});
  endtask
  // Let the output copies update
  task settle;
    repeat (2) @(posedge pclk);
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    flash_ack <= 1;
    @(posedge pclk);
    flash_ack <= 0;
    rd(12'hBDC, 8'h85);
    rd(12'hBE0, 8'hA1);
    rd(12'hBE4, 8'hC3);
    chk(temp_threshold_voltage, 32'h5);
    chk(flash_req, 32'h0);
    rd(12'h004, 8'h00);
    chk(pslverr, 32'h1);
    rd(12'hBDC, 8'h85);
    chk(pslverr, 32'h0);
    $display("Flash load test done");
    wr(12'hBD8, 8'h5A);
    rd(12'hBD8, 8'h00);
    special_mode <= 1;
    wr(12'hBD8, 8'h5A);
    rd(12'hBD8, 8'h5A);
    $display("Test register test done");
    wr(12'hBDC, 8'h7F);
    rd(12'hBDC, 8'h0F);
    settle;
    chk(temp_threshold_voltage, 32'h0);
    wr(12'hBDC, 8'h8A);
    settle;
    chk(temp_threshold_voltage, 32'hA);
    $display("Temperature trim test done");
    register_protect <= 1;
    pll_select <= 1;
    wr(12'hBE0, 8'hFF);
    rd(12'hBE0, 8'hA1);
    chk(n_clr, 32'h0);
    register_protect <= 0;
    wr(12'hBE0, 8'hFF);
    rd(12'hBE0, 8'hFB);
    chk(n_clr, 32'h1);
    pll_select <= 0;
    wr(12'hBE0, 8'h83);
    wr(12'hBE4, 8'hC5);
    settle;
    chk(n_clr, 32'h1);
    chk(tempco_comp_on, 32'h0);
    chk(freq_coarse_trim, 32'hF);
    chk(freq_fine_trim, 32'h5);
    wr(12'hBE0, 8'h08);
    settle;
    chk(tempco_comp_on, 32'h1);
    chk(freq_trim_field, 32'h0C5);
    $display("Oscillator trim test done");
    conclude;
  end
endmodule
